// File: eifv_top.sv
// External pin interrupt flags, W1C flag register and vector request to the core
// How it works
// - Vectors in fixed order: reset 0x000, pin 0 0x001, pin 1 0x002, last 0x015.
// - Flag register: pin 1 flag bit 1, pin 0 flag bit 0, reset zero.
// - A qualifying edge or change on a pin sets that pin's flag.
// - Vector requested only while global enable and the pin's mask are set.
// - Entering the service routine through the vector clears that flag.
// - Writing one clears a flag; writing zero leaves it unchanged.
// - A pin in level-sense mode keeps its flag cleared.
// - Register answers at data offset 0x3C and at I/O offset 0x1C.
module eifv_top
   import eifv_pkg::*;
(
   input wire logic clk_sys, // 50 MHz system clock
   input wire logic reset_n, // Asynchronous reset, active low
   input wire logic clk_en, // Freezes all state while low
   input wire logic [1:0] pin_irq, // External interrupt pins, asynchronous
   input eifv_sense_t sense_mode [2], // Sense control per pin
   input wire logic [1:0] pin_irq_mask_reg, // Per-pin interrupt mask
   input wire logic global_int_en, // Global enable bit of core_status_reg
   input eifv_bus_t bus, // Load/store and in/out access
   input wire logic vec_ack, // Core entered the vector on irq_vector
   output logic [7:0] reg_rdata, // Read data, valid the cycle after rd
   output logic irq_req, // Vectored interrupt request
   output logic [5:0] irq_vector // Vector slot of the request
);
   eifv_state_t st_r;
   eifv_state_t st_nxt;
   logic [1:0] set_ev;
   logic [1:0] level_on;
   logic [1:0] lvl_req;
   logic hit;

   assign hit = bus.io_space ? (bus.addr == EIFV_FLAGS_IO_OFS) : (bus.addr == EIFV_FLAGS_DATA_OFS);

   // Edge qualification looks only at the second synchroniser stage
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_pin
         // Continuous assigns, so that each bit of the shared vectors has a single clean driver
         assign level_on[gi] = (sense_mode[gi] == EIFV_SENSE_LOW);
         assign lvl_req[gi] = level_on[gi] & ~st_r.sync2[gi];
         assign set_ev[gi] = (sense_mode[gi] == EIFV_SENSE_ANY) ? (st_r.sync2[gi] ^ st_r.prev[gi]) :
                             (sense_mode[gi] == EIFV_SENSE_FALL) ? (st_r.prev[gi] & ~st_r.sync2[gi]) :
                             (sense_mode[gi] == EIFV_SENSE_RISE) ? (~st_r.prev[gi] & st_r.sync2[gi]) :
                             1'b0;
      end
   endgenerate

   always_comb begin
      logic [1:0] clr;
      logic [1:0] pend;
      clr = 2'b00;
      pend = 2'b00;
      st_nxt = st_r;
      st_nxt.sync1 = pin_irq;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.prev = st_r.sync2;
      if (bus.wr && hit) begin
         clr = bus.wdata[1:0];
      end
      if (vec_ack && st_r.irq_req) begin
         if (st_r.vec == EIFV_VEC_PIN0) begin
            clr[EIFV_FLAG0_BIT] = 1'b1;
         end else begin
            clr[EIFV_FLAG1_BIT] = 1'b1;
         end
      end
      // A new edge in the clearing cycle survives the clear
      st_nxt.flags = ((st_r.flags & ~clr) | set_ev) & ~level_on;
      pend = (st_nxt.flags | lvl_req) & pin_irq_mask_reg;
      st_nxt.irq_req = global_int_en & (|pend);
      // Pin 0 has the lower slot and so the higher priority
      st_nxt.vec = pend[0] ? EIFV_VEC_PIN0 : (pend[1] ? EIFV_VEC_PIN1 : EIFV_VEC_RESET);
      if (bus.rd && hit) begin
         st_nxt.rdata = {6'h00, st_r.flags};
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '{sync1: 2'h0, sync2: 2'h0, prev: 2'h0, flags: EIFV_FLAGS_RESET[1:0], irq_req: 1'b0,
                   vec: EIFV_VEC_RESET, rdata: 8'h00};
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;
   assign irq_req = st_r.irq_req;
   assign irq_vector = st_r.vec;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   chk_flag_set: assert property (clk_en && set_ev[0] |=> st_r.flags[0])
      else $error("pin 0 edge did not set its flag");
   chk_w1c_clear: assert property (clk_en && bus.wr && hit && bus.wdata[0] && !set_ev[0] &&
      !(vec_ack && st_r.irq_req) |=> !st_r.flags[0] || 1'b0)
      else $error("write of one did not clear pin 0 flag");
   chk_w0_keep: assert property (clk_en && bus.wr && hit && !bus.wdata[1] && st_r.flags[1] &&
      !level_on[1] && !(vec_ack && st_r.irq_req && st_r.vec == EIFV_VEC_PIN1) |=> st_r.flags[1])
      else $error("write of zero changed pin 1 flag");
   chk_level_clear: assert property (clk_en && level_on[1] |=> !st_r.flags[1])
      else $error("flag set in level-sense mode");
   chk_gie_gate: assert property (clk_en && !global_int_en |=> !irq_req)
      else $error("request raised without global enable");
   chk_mask_gate: assert property (irq_req && irq_vector == EIFV_VEC_PIN1 |-> $past(pin_irq_mask_reg[1]))
      else $error("pin 1 requested while masked");
   chk_vec_slot: assert property (irq_req |-> irq_vector == EIFV_VEC_PIN0 || irq_vector == EIFV_VEC_PIN1)
      else $error("request carries a wrong vector slot");
   chk_ack_clear: assert property (clk_en && vec_ack && irq_req && irq_vector == EIFV_VEC_PIN0 &&
      !set_ev[0] |=> !st_r.flags[0])
      else $error("vector entry did not clear pin 0 flag");
   chk_read_back: assert property (clk_en && bus.rd && hit |=> reg_rdata == {6'h00, $past(st_r.flags)})
      else $error("flag register read returned wrong data");
   chk_upper_zero: assert property (reg_rdata[7:2] == 6'h00)
      else $error("unused flag bits read nonzero");
   chk_freeze: assert property (!clk_en |=> $stable(st_r))
      else $error("state moved while clock enable low");

   cov_edge_vector: cover property (clk_en && set_ev[0] ##1 irq_req ##[1:4] vec_ack);
   cov_io_clear: cover property (clk_en && bus.wr && bus.io_space && hit && bus.wdata[1] && st_r.flags[1]);
   cov_level_req: cover property (irq_req && lvl_req[0]);
   cov_set_beats_clear: cover property (clk_en && set_ev[1] && bus.wr && hit && bus.wdata[1]);
endmodule : eifv_top

// File: eifv_pkg.sv
// Constants and carrier types for the external pin interrupt flag block
package eifv_pkg;
   localparam logic [8:0] EIFV_FLAGS_DATA_OFS = 9'h03C;
   localparam logic [8:0] EIFV_IO_BIAS = 9'h020;
   localparam logic [8:0] EIFV_FLAGS_IO_OFS = EIFV_FLAGS_DATA_OFS - EIFV_IO_BIAS;
   localparam int EIFV_FLAG0_BIT = 0;
   localparam int EIFV_FLAG1_BIT = 1;
   localparam logic [7:0] EIFV_FLAGS_RESET = 8'h00;
   localparam logic [5:0] EIFV_VEC_RESET = 6'h00;
   localparam logic [5:0] EIFV_VEC_PIN0 = 6'h01;
   localparam logic [5:0] EIFV_VEC_PIN1 = 6'h02;
   localparam logic [5:0] EIFV_VEC_LAST = 6'h15;

   typedef enum logic [1:0] {
      EIFV_SENSE_LOW,
      EIFV_SENSE_ANY,
      EIFV_SENSE_FALL,
      EIFV_SENSE_RISE
   } eifv_sense_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic io_space;
      logic [8:0] addr;
      logic [7:0] wdata;
   } eifv_bus_t;

   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [1:0] prev;
      logic [1:0] flags;
      logic irq_req;
      logic [5:0] vec;
      logic [7:0] rdata;
   } eifv_state_t;
endpackage : eifv_pkg

// File: eifv_core_model.sv
// Core model that enters a pending vector and remembers which slot it took
module eifv_core_model (
   input wire logic clk_sys, // System clock
   input wire logic reset_n, // Reset, active low
   input wire logic irq_req, // Request from the block
   input wire logic [5:0] irq_vector, // Requested slot
   input wire logic ack_en, // Core interrupts enabled
   output logic vec_ack, // Vector entered pulse
   output logic [5:0] last_vec // Slot last entered
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         vec_ack <= 1'b0;
         last_vec <= 6'h3F;
      end else begin
         // One cycle late on purpose, as a real core finishes its instruction first
         vec_ack <= irq_req & ack_en & !vec_ack;
         if (irq_req & ack_en & !vec_ack) last_vec <= irq_vector;
      end
   end
endmodule : eifv_core_model

// File: eifv_top_bench.sv
// Self-checking bench for the external pin interrupt flag block
module eifv_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import eifv_pkg::*;
   logic clk_sys = 0, reset_n = 0, gie = 0, ack, irq_req;
   logic [1:0] pins = 2'h3, mask = 2'h0;
   eifv_sense_t sense [2];
   eifv_bus_t bus = '0;
   logic [7:0] rdata;
   logic [5:0] irq_vector, last_vec;
   int failures = 0, n_checks = 0;
   always #10 clk_sys = ~clk_sys;
   eifv_top i_eifv_top (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1), .pin_irq(pins), .sense_mode(sense),
      .pin_irq_mask_reg(mask), .global_int_en(gie), .bus(bus), .vec_ack(ack), .reg_rdata(rdata),
      .irq_req(irq_req), .irq_vector(irq_vector));
   eifv_core_model i_eifv_core_model (.clk_sys(clk_sys), .reset_n(reset_n), .irq_req(irq_req),
      .irq_vector(irq_vector), .ack_en(gie), .vec_ack(ack), .last_vec(last_vec));
   task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic tick(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic access(logic io, logic wr, logic [7:0] wd);
      bus = '{rd: !wr, wr: wr, io_space: io, addr: io ? EIFV_FLAGS_IO_OFS : EIFV_FLAGS_DATA_OFS, wdata: wd};
      tick(1);
      bus = '0;
      tick(1);
   endtask : access
   task automatic t_reset;
      access(1'b0, 1'b0, 8'h00);
      cmp("flags after reset", EIFV_FLAGS_RESET, rdata);
   endtask : t_reset
   task automatic t_edge_w1c;
      gie = 1'b1;
      sense[0] = EIFV_SENSE_RISE;
      pins[0] = 1'b0;
      tick(4);
      pins[0] = 1'b1;
      tick(4);
      cmp("request while masked", 8'h00, {7'h00, irq_req});
      access(1'b1, 1'b0, 8'h00);
      cmp("flags after rise", 8'h01, rdata);
      access(1'b1, 1'b1, 8'hFE);
      access(1'b0, 1'b0, 8'h00);
      cmp("flags after zero write", 8'h01, rdata);
      access(1'b1, 1'b1, 8'hFF);
      access(1'b1, 1'b0, 8'h00);
      cmp("flags after one write", 8'h00, rdata);
   endtask : t_edge_w1c
   task automatic t_vector;
      mask = 2'h2;
      pins[1] = 1'b0;
      tick(8);
      cmp("vector entered", {2'h0, EIFV_VEC_PIN1}, {2'h0, last_vec});
      access(1'b0, 1'b0, 8'h00);
      cmp("flags after vector", 8'h00, rdata);
   endtask : t_vector
   task automatic t_level;
      sense[0] = EIFV_SENSE_LOW;
      pins[0] = 1'b0;
      tick(6);
      access(1'b0, 1'b0, 8'h00);
      cmp("flags in level mode", 8'h00, rdata);
      mask = 2'h1;
      tick(4);
      cmp("level request", 8'h01, {7'h00, irq_req});
      cmp("level vector", {2'h0, EIFV_VEC_PIN0}, {2'h0, irq_vector});
      cmp("level vector entered", {2'h0, EIFV_VEC_PIN0}, {2'h0, last_vec});
      access(1'b0, 1'b0, 8'h00);
      cmp("flags after level ack", 8'h00, rdata);
      mask = 2'h0;
   endtask : t_level
   task automatic print_verdict;
      if (failures == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   initial begin
      sense = '{EIFV_SENSE_FALL, EIFV_SENSE_FALL};
      tick(4);
      reset_n = 1'b1;
      tick(1);
      t_reset;
      t_edge_w1c;
      t_vector;
      t_level;
      print_verdict;
   end
   initial begin
      #20000;
      failures++;
      print_verdict;
   end
endmodule : eifv_top_bench
